/* File: hdl/bcs_consts.svh */
// Constants for the buck clock sync and load monitor block
// Overview of operation
// - Selection write picks buck and starts measurement
// - Selected buck forced to PWM while measuring
// - Measurement finishes within 50 us
// - Finished measurement sets measure done flag
// - Measure done mask keeps flag off interrupt
// - Result bits 7:0 low, bit 8 high
// - One result count equals 20 mA
// - Auto mode: PWM at 600 mA and above, else PFM
// - Forced PWM keeps fixed frequency, never PFM
// - Dither only with PLL off, both bucks
// - Dither sweeps frequency around its center
// - Clock source and interrupt follow PLL, validity
// - Sync mask keeps sync flag off interrupt
// - Five-bit nominal external rate, 1 to 24 MHz
// - External clock valid only within -30%/+10%
// - PLL on, no clock at transitions: interrupt
// - Sync input pin reusable as second output
// - Each output open-drain or push-pull selectable
// - Buck parameter reset values come from OTP
// - PLL off: internal clock; on: auto switch, interrupt
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
`define BCS_OFS_CTRL 8'h00
`define BCS_OFS_PLL 8'h01
`define BCS_OFS_SEL 8'h02
`define BCS_OFS_RES_LO 8'h03
`define BCS_OFS_RES_HI 8'h04
`define BCS_OFS_INT 8'h05
`define BCS_OFS_MASK 8'h06
`define BCS_OFS_STAT 8'h07
`define BCS_CTRL_DITHER 2
`define BCS_CTRL_SECOND_GENERAL_OUTPUT_MODE 3
`define BCS_CTRL_SECOND_GENERAL_OUTPUT_LVL 4
`define BCS_CTRL_SECOND_GENERAL_OUTPUT_OD 5
`define BCS_CTRL_GPO_LVL 6
`define BCS_CTRL_GPO_OD 7
`define BCS_PLL_EN 6
`define BCS_INT_MEAS 0
`define BCS_INT_SYNC 1
`define BCS_CTRL_RST 8'h00
`define BCS_PLL_RST 8'h00
`define BCS_MASK_RST 8'h00
`define BCS_CLK_PERIOD_NS 10
`define BCS_MEAS_TIME_NS 50000
`define BCS_MEAS_CYCLES (`BCS_MEAS_TIME_NS / `BCS_CLK_PERIOD_NS)
`define BCS_WIN_NS 10000
`define BCS_WIN_CYCLES (`BCS_WIN_NS / `BCS_CLK_PERIOD_NS)
`define BCS_TOL_LO_PCT 70
`define BCS_TOL_HI_PCT 110
`define BCS_RATE_MAX 24
`define BCS_LSB_MA 20
`define BCS_PWM_LOAD_MA 600
`define BCS_PWM_CODE (`BCS_PWM_LOAD_MA / `BCS_LSB_MA)
`define BCS_DITHER_STEP 64
`endif

/* File: hdl/bcs_pkg.sv */
// Types shared by the buck clock sync and load monitor block
package bcs_pkg;
    typedef enum logic {BCS_MEAS_IDLE, BCS_MEAS_RUN} bcs_meas_state_t;
    typedef logic [8:0] bcs_load_code_t;
endpackage

/* File: hdl/bcs_clkmon_if.sv */
// Link between the control core and the sync clock monitor
`timescale 1ns/1ps
interface bcs_clkmon_if;
    logic [4:0] nominal_rate;
    logic enable;
    logic valid;
    modport ctrl (output nominal_rate, output enable, input valid);
    modport mon (input nominal_rate, input enable, output valid);
endinterface

/* File: hdl/bcs_clkmon.sv */
// Sync clock frequency window monitor
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_clkmon (
    // Clock and reset
    input logic i_clk,
    input logic i_rst,
    // Sync pin and control link
    input logic i_pin,
    bcs_clkmon_if.mon mon
);
    logic s1_r, s2_r, s3_r, lvl_r, edge_w, win_end_w, in_range_w;
    logic [15:0] win_cnt_r;
    logic [8:0] edges_r, lo_w, hi_w;

    // Edge only once second and third stages agree
    assign edge_w = (s2_r == s3_r) && s3_r && !lvl_r;
    assign win_end_w = (win_cnt_r == 16'(`BCS_WIN_CYCLES - 1));
    // Edges per window scaled from the nominal MHz
    assign lo_w = 9'(32'(mon.nominal_rate) * `BCS_WIN_NS
                  * `BCS_TOL_LO_PCT / 100000);
    assign hi_w = 9'(32'(mon.nominal_rate) * `BCS_WIN_NS
                  * `BCS_TOL_HI_PCT / 100000);
    // Codes 0 and above 24 MHz never count as valid
    assign in_range_w = (mon.nominal_rate != 5'h00)
                     && (mon.nominal_rate <= 5'(`BCS_RATE_MAX))
                     && (edges_r >= lo_w) && (edges_r <= hi_w);

    always_ff @(posedge i_clk) begin
        s1_r <= i_pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !mon.enable) begin
            lvl_r <= 1'b0;
            win_cnt_r <= 16'h0000;
            edges_r <= 9'h000;
            mon.valid <= 1'b0;
        end else begin
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
            win_cnt_r <= win_end_w ? 16'h0000 : win_cnt_r + 16'h0001;
            if (win_end_w) begin
                mon.valid <= in_range_w;
                edges_r <= 9'h000;
            end else if (edge_w && edges_r != 9'h1FF) begin
                edges_r <= edges_r + 9'h001;
            end
        end
    end
endmodule // bcs_clkmon

/* File: hdl/bcs_top.sv */
// Clock selection, PWM/PFM mode and load measurement control
`timescale 1ns/1ps
`include "bcs_consts.svh"
module bcs_top #(
    parameter int MEAS_CYCLES = `BCS_MEAS_CYCLES
) (
    // Clock and reset
    input logic i_clk,
    input logic i_rst,
    // Register port
    input logic [7:0] i_reg_addr,
    input logic i_reg_wr,
    input logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // OTP defaults and device state transitions
    input logic [1:0] i_otp_fpwm,
    input logic i_to_standby,
    input logic i_to_active,
    // Average load current codes per buck
    input logic [1:0][8:0] i_load_avg,
    // Buck and clock controls
    output logic [1:0] o_buck_pwm,
    output logic o_use_ext_clock,
    output logic o_dither_active,
    output logic [3:0] o_freq_trim,
    output logic o_irq,
    // Sync pin, doubles as second output
    input logic i_sync_pin,
    output logic o_sync_pin_out,
    output logic o_sync_pin_oe_n,
    // Dedicated general output
    output logic o_gpo_out,
    output logic o_gpo_oe_n
);
    bcs_clkmon_if mon_if ();

    logic [7:0] ctrl_r, pll_r, mask_r, rdata_nxt;
    logic [1:0] fpwm_r, int_r, int_set_w, int_clr_w;
    logic sel_r, valid_d_r, meas_end_w, sel_wr_w;
    logic pll_en_w, sync_evt_w, second_general_output_mode_w, dither_w;
    logic [15:0] meas_cnt_r;
    logic [5:0] dith_cnt_r;
    logic [3:0] trim_r;
    logic trim_up_r;
    bcs_pkg::bcs_meas_state_t meas_st_r;
    bcs_pkg::bcs_load_code_t res_r;
    logic [1:0] lvl_w, od_w, drv_en_w, pin_out_w, pin_oe_n_w;

    // Register decode
    assign sel_wr_w = i_reg_wr && (i_reg_addr == `BCS_OFS_SEL);
    assign int_clr_w = (i_reg_wr && i_reg_addr == `BCS_OFS_INT)
                     ? i_reg_wdata[1:0] : 2'h0;
    assign pll_en_w = pll_r[`BCS_PLL_EN];
    assign second_general_output_mode_w = ctrl_r[`BCS_CTRL_SECOND_GENERAL_OUTPUT_MODE];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r <= `BCS_CTRL_RST;
            pll_r <= `BCS_PLL_RST;
            mask_r <= `BCS_MASK_RST;
            fpwm_r <= i_otp_fpwm;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `BCS_OFS_CTRL: begin
                    ctrl_r <= i_reg_wdata;
                    fpwm_r <= i_reg_wdata[1:0];
                end
                `BCS_OFS_PLL: pll_r <= i_reg_wdata & 8'h5F;
                `BCS_OFS_MASK: mask_r <= i_reg_wdata & 8'h03;
                default: ;
            endcase
        end
    end

    // Read data comes out registered, unmapped reads give zero
    always_comb begin
        case (i_reg_addr)
            `BCS_OFS_CTRL: rdata_nxt = {ctrl_r[7:2], fpwm_r};
            `BCS_OFS_PLL: rdata_nxt = pll_r;
            `BCS_OFS_SEL: rdata_nxt = {7'h00, sel_r};
            `BCS_OFS_RES_LO: rdata_nxt = res_r[7:0];
            `BCS_OFS_RES_HI: rdata_nxt = {7'h00, res_r[8]};
            `BCS_OFS_INT: rdata_nxt = {6'h00, int_r};
            `BCS_OFS_MASK: rdata_nxt = mask_r;
            `BCS_OFS_STAT: rdata_nxt = {5'h00, o_use_ext_clock,
                                        meas_st_r == bcs_pkg::BCS_MEAS_RUN,
                                        mon_if.valid};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= rdata_nxt;
        end
    end

    // Load measurement sequencer
    assign meas_end_w = (meas_st_r == bcs_pkg::BCS_MEAS_RUN)
                     && (meas_cnt_r == 16'(MEAS_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meas_st_r <= bcs_pkg::BCS_MEAS_IDLE;
            meas_cnt_r <= 16'h0000;
            sel_r <= 1'b0;
            res_r <= 9'h000;
        end else if (sel_wr_w) begin
            // A new write restarts even a running sequence
            sel_r <= i_reg_wdata[0];
            meas_st_r <= bcs_pkg::BCS_MEAS_RUN;
            meas_cnt_r <= 16'h0000;
        end else begin
            case (meas_st_r)
                bcs_pkg::BCS_MEAS_IDLE: meas_cnt_r <= 16'h0000;
                bcs_pkg::BCS_MEAS_RUN: begin
                    meas_cnt_r <= meas_cnt_r + 16'h0001;
                    if (meas_end_w) begin
                        res_r <= i_load_avg[sel_r];
                        meas_st_r <= bcs_pkg::BCS_MEAS_IDLE;
                    end
                end
                default: meas_st_r <= bcs_pkg::BCS_MEAS_IDLE;
            endcase
        end
    end

    // PWM/PFM mode per buck
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_buck
            assign o_buck_pwm[b] = fpwm_r[b]
                || (i_load_avg[b] >= 9'(`BCS_PWM_CODE))
                || (meas_st_r == bcs_pkg::BCS_MEAS_RUN
                    && sel_r == 1'(b));
        end
    endgenerate

    // Clock source selection and monitor link
    assign mon_if.nominal_rate = pll_r[4:0];
    assign mon_if.enable = pll_en_w && !second_general_output_mode_w;
    assign o_use_ext_clock = pll_en_w && mon_if.valid;

    bcs_clkmon u_clkmon (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_sync_pin),
        .mon(mon_if.mon)
    );

    // Sync interrupt: clock appears or vanishes, or missing on entry
    assign sync_evt_w = pll_en_w && ((mon_if.valid != valid_d_r)
        || ((i_to_standby || i_to_active) && !mon_if.valid));
    assign int_set_w = {sync_evt_w, meas_end_w};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            valid_d_r <= 1'b0;
            int_r <= 2'h0;
        end else begin
            valid_d_r <= mon_if.valid;
            // Set wins over a clear in the same cycle
            int_r <= int_set_w | (int_r & ~int_clr_w);
        end
    end

    assign o_irq = |(int_r & ~mask_r[1:0]);

    // Spread spectrum triangle sweep, internal oscillator only
    assign dither_w = ctrl_r[`BCS_CTRL_DITHER] && !pll_en_w;
    assign o_dither_active = dither_w;
    assign o_freq_trim = trim_r;

    always_ff @(posedge i_clk) begin
        if (i_rst || !dither_w) begin
            dith_cnt_r <= 6'h00;
            trim_r <= 4'h8;
            trim_up_r <= 1'b1;
        end else begin
            dith_cnt_r <= dith_cnt_r + 6'h01;
            if (dith_cnt_r == 6'(`BCS_DITHER_STEP - 1)) begin
                // Sweep stays in 1..F around the 8 center
                trim_r <= trim_up_r ? trim_r + 4'h1 : trim_r - 4'h1;
                if (trim_up_r && trim_r == 4'hE) begin
                    trim_up_r <= 1'b0;
                end else if (!trim_up_r && trim_r == 4'h2) begin
                    trim_up_r <= 1'b1;
                end
            end
        end
    end

    // Output drivers: index 0 dedicated output, 1 the sync pin
    assign lvl_w = {ctrl_r[`BCS_CTRL_SECOND_GENERAL_OUTPUT_LVL], ctrl_r[`BCS_CTRL_GPO_LVL]};
    assign od_w = {ctrl_r[`BCS_CTRL_SECOND_GENERAL_OUTPUT_OD], ctrl_r[`BCS_CTRL_GPO_OD]};
    assign drv_en_w = {second_general_output_mode_w, 1'b1};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_gpo
            // Open drain only pulls low, high is released
            assign pin_out_w[g] = od_w[g] ? 1'b0 : lvl_w[g];
            assign pin_oe_n_w[g] = !drv_en_w[g]
                || (od_w[g] && lvl_w[g]);
        end
    endgenerate

    assign o_gpo_out = pin_out_w[0];
    assign o_gpo_oe_n = pin_oe_n_w[0];
    assign o_sync_pin_out = pin_out_w[1];
    assign o_sync_pin_oe_n = pin_oe_n_w[1];

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_sel_start;
        sel_wr_w |=> meas_st_r == bcs_pkg::BCS_MEAS_RUN
            && sel_r == $past(i_reg_wdata[0]) && meas_cnt_r == 16'h0000;
    endproperty
    a_sel_start: assert property (p_sel_start)
        else $error("selection write did not start measurement");

    property p_meas_pwm;
        meas_st_r == bcs_pkg::BCS_MEAS_RUN |-> o_buck_pwm[sel_r];
    endproperty
    a_meas_pwm: assert property (p_meas_pwm)
        else $error("measured buck not forced to PWM");

    property p_meas_bound;
        meas_st_r == bcs_pkg::BCS_MEAS_RUN
            |-> meas_cnt_r < 16'(MEAS_CYCLES);
    endproperty
    a_meas_bound: assert property (p_meas_bound)
        else $error("measurement ran past its limit");

    property p_meas_done;
        meas_end_w && !sel_wr_w |=> int_r[`BCS_INT_MEAS]
            && meas_st_r == bcs_pkg::BCS_MEAS_IDLE
            && res_r == $past(i_load_avg[sel_r]);
    endproperty
    a_meas_done: assert property (p_meas_done)
        else $error("measurement end did not flag or store result");

    property p_mask_meas;
        mask_r[`BCS_INT_MEAS] && !(int_r[`BCS_INT_SYNC]
            && !mask_r[`BCS_INT_SYNC]) |-> !o_irq;
    endproperty
    a_mask_meas: assert property (p_mask_meas)
        else $error("masked measure flag raised interrupt");

    property p_mask_sync;
        mask_r[`BCS_INT_SYNC] && !(int_r[`BCS_INT_MEAS]
            && !mask_r[`BCS_INT_MEAS]) |-> !o_irq;
    endproperty
    a_mask_sync: assert property (p_mask_sync)
        else $error("masked sync flag raised interrupt");

    property p_fpwm;
        fpwm_r[0] && fpwm_r[1] |-> o_buck_pwm == 2'h3;
    endproperty
    a_fpwm: assert property (p_fpwm)
        else $error("forced PWM buck left PWM");

    property p_dither_pll;
        pll_en_w |-> !o_dither_active ##1 (trim_r == 4'h8 || pll_en_w == 1'b0);
    endproperty
    a_dither_pll: assert property (p_dither_pll)
        else $error("dither active with PLL enabled");

    property p_no_pll;
        !pll_en_w |-> !o_use_ext_clock ##1 !int_set_w[`BCS_INT_SYNC]
            || $past(pll_en_w) == 1'b0 && pll_en_w;
    endproperty
    a_no_pll: assert property (p_no_pll)
        else $error("PLL off yet external clock or sync event");

    property p_sticky;
        int_r[`BCS_INT_MEAS] && !int_clr_w[`BCS_INT_MEAS]
            |=> int_r[`BCS_INT_MEAS];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("measure flag cleared without software");

    property p_res_lo;
        i_reg_addr == `BCS_OFS_RES_LO |=> o_reg_rdata == $past(res_r[7:0]);
    endproperty
    a_res_lo: assert property (p_res_lo)
        else $error("result low byte not readable");

    property p_res_hi;
        i_reg_addr == `BCS_OFS_RES_HI
            |=> o_reg_rdata == {7'h00, $past(res_r[8])};
    endproperty
    a_res_hi: assert property (p_res_hi)
        else $error("result top bit not readable");

    property p_auto_pwm;
        !fpwm_r[0] && meas_st_r == bcs_pkg::BCS_MEAS_IDLE
            |-> o_buck_pwm[0] == (i_load_avg[0] >= 9'(`BCS_PWM_CODE));
    endproperty
    a_auto_pwm: assert property (p_auto_pwm)
        else $error("auto mode picked wrong PWM/PFM state");

    property p_trim_step;
        dither_w && dith_cnt_r == 6'(`BCS_DITHER_STEP - 1)
            |=> trim_r != $past(trim_r) && trim_r != 4'h0;
    endproperty
    a_trim_step: assert property (p_trim_step)
        else $error("dither sweep stalled or left its range");

    property p_sync_evt;
        pll_en_w && mon_if.valid != $past(mon_if.valid)
            |=> int_r[`BCS_INT_SYNC];
    endproperty
    a_sync_evt: assert property (p_sync_evt)
        else $error("clock change raised no sync flag");

    property p_entry_miss;
        pll_en_w && !mon_if.valid && (i_to_standby || i_to_active)
            |=> int_r[`BCS_INT_SYNC];
    endproperty
    a_entry_miss: assert property (p_entry_miss)
        else $error("missing clock at transition not flagged");

    property p_rate_reg;
        i_reg_wr && i_reg_addr == `BCS_OFS_PLL
            |=> mon_if.nominal_rate == $past(i_reg_wdata[4:0]);
    endproperty
    a_rate_reg: assert property (p_rate_reg)
        else $error("nominal rate not passed to monitor");

    property p_pin_release;
        !second_general_output_mode_w |-> o_sync_pin_oe_n;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("sync pin driven while used as input");

    property p_mon_off;
        second_general_output_mode_w |=> !mon_if.valid;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("monitor valid while pin is an output");

    property p_open_drain;
        ctrl_r[`BCS_CTRL_GPO_OD]
            |-> !o_gpo_out && o_gpo_oe_n == ctrl_r[`BCS_CTRL_GPO_LVL];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain output drove high");

    property p_otp_load;
        $past(i_rst) |-> fpwm_r == $past(i_otp_fpwm);
    endproperty
    a_otp_load: assert property (p_otp_load)
        else $error("forced PWM default not taken at reset");
endmodule // bcs_top

/* File: tb/bcs_clk_src.sv */
// External sync clock source model
`timescale 1ns/1ps
module bcs_clk_src (
    // Control from the bench
    input wire logic i_en,
    input wire logic [7:0] i_half_ns,
    // Clock onto the sync pin
    output logic o_clk
);
    // Stands low when stopped; off-rate only when the bench asks
    initial o_clk = 1'b0;
    always begin
        wait (i_en);
        #(i_half_ns) o_clk = 1'b1;
        #(i_half_ns) o_clk = 1'b0;
    end
endmodule // bcs_clk_src

/* File: tb/buck_clock_sync_and_load_monitor_tb.sv */
// Self-checking bench for the clock sync and load monitor block
`timescale 1ns/1ps
module buck_clock_sync_and_load_monitor_tb;
    localparam int MEAS = 20;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic stby = 1'b0;
    logic act = 1'b0;
    logic [1:0][8:0] load = '0;
    logic [1:0] otp = 2'b10;
    logic src_en = 1'b0;
    logic [7:0] half = 8'h32;
    logic [7:0] rdata;
    logic [1:0] pwm;
    logic [3:0] trim;
    logic use_ext, dith, irq, src_clk, pin;
    logic pin_out, pin_oe_n, gpo_out, gpo_oe_n;
    int error_cnt = 0;
    int n_compared = 0;

    always #5 i_clk = ~i_clk;
    // Design drive wins; a stopped source leaves the line low
    assign pin = !pin_oe_n ? pin_out : src_clk;

    bcs_clk_src src (.i_en(src_en), .i_half_ns(half), .o_clk(src_clk));

    bcs_top #(.MEAS_CYCLES(MEAS)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_otp_fpwm(otp), .i_to_standby(stby), .i_to_active(act),
        .i_load_avg(load), .o_buck_pwm(pwm), .o_use_ext_clock(use_ext),
        .o_dither_active(dith), .o_freq_trim(trim), .o_irq(irq),
        .i_sync_pin(pin), .o_sync_pin_out(pin_out),
        .o_sync_pin_oe_n(pin_oe_n), .o_gpo_out(gpo_out),
        .o_gpo_oe_n(gpo_oe_n)
    );

    task automatic test_done;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        wr = 1'b1;
        wdata = d;
        @(negedge i_clk);
        wr = 1'b0;
    endtask

    // Read data is registered: look one cycle after the address
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        addr = a;
        @(negedge i_clk);
        chk(rdata, exp);
    endtask

    task automatic pulse_evt(input logic is_act);
        @(negedge i_clk);
        stby = !is_act;
        act = is_act;
        @(negedge i_clk);
        stby = 1'b0;
        act = 1'b0;
    endtask

    task automatic meas(input int b, input logic [8:0] ld);
        int n;
        n = 0;
        load[b] = ld;
        wreg(8'h02, 8'(b));
        chkb(pwm[b], 1'b1);
        while (irq !== 1'b1) begin
            @(negedge i_clk);
            n++;
            if (n > MEAS) begin
                chkb(1'b0, 1'b1);
                test_done();
            end
        end
        chkb(n == MEAS, 1'b1);
        chkb(pwm[b], ld >= 9'h01E);
        rreg(8'h03, ld[7:0]);
        rreg(8'h04, {7'h00, ld[8]});
        rreg(8'h05, 8'h01);
    endtask

    task automatic t_reset;
        rreg(8'h00, 8'h02);
        rreg(8'h01, 8'h00);
        rreg(8'h06, 8'h00);
        chkb(pwm[1], 1'b1);
        chk({4'h0, trim}, 8'h08);
        chkb(irq, 1'b0);
        wreg(8'h09, 8'hFF);
        rreg(8'h09, 8'h00);
    endtask

    task automatic t_meas;
        wreg(8'h00, 8'h00);
        chkb(pwm[1], 1'b0);
        meas(0, 9'h01D);
        wreg(8'h06, 8'h01);
        chkb(irq, 1'b0);
        rreg(8'h05, 8'h01);
        wreg(8'h05, 8'h01);
        rreg(8'h05, 8'h00);
        wreg(8'h06, 8'h00);
        meas(1, 9'h1FF);
        wreg(8'h05, 8'h01);
    endtask

    task automatic t_sync;
        logic [7:0] hs [3] = '{8'h4B, 8'h46, 8'h28};
        half = 8'h32;
        src_en = 1'b1;
        wreg(8'h01, 8'h4A);
        cyc(2500);
        rreg(8'h07, 8'h05);
        chkb(use_ext, 1'b1);
        rreg(8'h05, 8'h02);
        chkb(irq, 1'b1);
        wreg(8'h06, 8'h02);
        chkb(irq, 1'b0);
        wreg(8'h05, 8'h02);
        // Below, inside and above the -30%/+10% window at 10 MHz
        for (int i = 0; i < 3; i++) begin
            half = hs[i];
            cyc(2500);
            rreg(8'h07, (i == 1) ? 8'h05 : 8'h00);
            rreg(8'h05, 8'h02);
            wreg(8'h05, 8'h02);
        end
        src_en = 1'b0;
        cyc(2500);
        pulse_evt(1'b0);
        rreg(8'h05, 8'h02);
        wreg(8'h05, 8'h02);
        pulse_evt(1'b1);
        rreg(8'h05, 8'h02);
        wreg(8'h05, 8'h02);
        wreg(8'h06, 8'h00);
    endtask

    task automatic t_dither;
        logic [3:0] t0;
        wreg(8'h00, 8'h04);
        chkb(dith, 1'b0);
        half = 8'h32;
        src_en = 1'b1;
        wreg(8'h01, 8'h0A);
        cyc(2500);
        rreg(8'h05, 8'h00);
        chkb(use_ext, 1'b0);
        chkb(dith, 1'b1);
        t0 = trim;
        cyc(130);
        chkb(trim != t0, 1'b1);
        wreg(8'h00, 8'h00);
        chkb(dith, 1'b0);
        src_en = 1'b0;
    endtask

    task automatic t_gpo;
        wreg(8'h00, 8'h58);
        chkb(pin_oe_n, 1'b0);
        chkb(pin_out, 1'b1);
        chkb(gpo_oe_n, 1'b0);
        chkb(gpo_out, 1'b1);
        wreg(8'h00, 8'hB8);
        chkb(pin_oe_n, 1'b1);
        chkb(gpo_oe_n, 1'b0);
        chkb(gpo_out, 1'b0);
    endtask

    // Mid-run reset must reload the other OTP default
    task automatic t_rst2;
        otp = 2'b01;
        i_rst = 1'b1;
        cyc(3);
        i_rst = 1'b0;
        rreg(8'h00, 8'h01);
        chkb(pwm[0], 1'b1);
        chkb(pin_oe_n, 1'b1);
    endtask

    initial begin
        cyc(12);
        i_rst = 1'b0;
        t_reset();
        t_meas();
        t_sync();
        t_dither();
        t_gpo();
        t_rst2();
        test_done();
    end
endmodule // buck_clock_sync_and_load_monitor_tb
